// ==== dv/rca_arbiter_ctrl_properties.sv ====
// Port-level checks of the coexistence arbiter control block
`timescale 1ns/1ps
module rca_arbiter_ctrl_chk #(
   parameter ADDR_W = 12,
   parameter DIAG_W = 8
) (
   // Clock and reset
   input wire clock,
   input wire reset_n,
   // Register bus
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   // Arbiter side
   input wire macEventInProcess,
   input wire radioCtrlBusy,
   input wire macRadioBusy,
   input wire externalRequest1,
   input wire coexRxIndicator,
   input wire [DIAG_W-1:0] macDiagIn,
   input wire [DIAG_W-1:0] diagOut,
   input wire ownActivityOut,
   input wire ownPriorityOut,
   input wire [1:0] grantDecision,
   input wire decisionClosing
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence sCloseStart;
      decisionClosing && grantDecision != 2'h0;
   endsequence
   sequence sClosed;
      !decisionClosing && grantDecision == 2'h0;
   endsequence
   AST_DEC_CODE: assert property (grantDecision != 2'h2)
      else $error("reserved decision code");
   AST_CLOSE_ONE: assert property (
      decisionClosing |-> sCloseStart ##1 sClosed)
      else $error("closing not followed by no grant");
   AST_NO_SWAP: assert property (
      $changed(grantDecision) && $past(grantDecision) != 2'h0
      |-> grantDecision == 2'h0)
      else $error("grant changed without passing no grant");
   AST_PRI: assert property (
      ownPriorityOut == ($past(grantDecision) == 2'h1))
      else $error("priority pin does not follow grant");
   AST_OWN_ACT: assert property (
      ownActivityOut |-> $past(macEventInProcess))
      else $error("own activity without internal request");
   AST_BUSY: assert property (
      macRadioBusy |->
      $past(radioCtrlBusy, 2) || $past(grantDecision) == 2'h3)
      else $error("radio busy without cause");
   AST_RX_IND: assert property (
      coexRxIndicator |->
      $past(externalRequest1, 2) || $past(externalRequest1, 3))
      else $error("rx indicator without request");
   AST_DIAG_TOP: assert property (
      diagOut[DIAG_W-1:6] == $past(macDiagIn[DIAG_W-1:6]))
      else $error("diag upper bits altered");
   AST_B_HOLD: assert property (
      s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_R_HOLD: assert property (
      s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule
bind rca_arbiter_ctrl rca_arbiter_ctrl_chk #(.ADDR_W(ADDR_W),
   .DIAG_W(DIAG_W)) chk (.*);

// ==== dv/rca_arbiter_ctrl_tb.sv ====
// Self-checking bench of the coexistence arbiter control block
`timescale 1ns/1ps
`include "rca_defs.vh"
module rca_arbiter_ctrl_tb;
   logic clock = 1'b0, reset_n = 1'b0, awValid = 0, wValid = 0, bReady = 0;
   logic arValid = 0, rReady = 0, macEvt = 0, radioBusy = 0, wantTx = 0;
   logic wantRx = 0, slow = 0, awReady, wReady, bValid, arReady, rValid;
   logic macBusy, txInd, rxInd, ownAct, ownPri, closing, ext0, ext1;
   logic [11:0] awAddr = '0, arAddr = '0;
   logic [31:0] wData = '0, rData, rv;
   logic [1:0] bResp, rResp, dec, lastResp, decM = 2'h0;
   logic [7:0] diagIn = '0, diagOut;
   logic [15:0] ctrl = '0;
   int n_fail = 0, check_count = 0, seed;
   rca_arbiter_ctrl uut (.clock(clock), .reset_n(reset_n),
      .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .macEventInProcess(macEvt),
      .radioCtrlBusy(radioBusy), .macRadioBusy(macBusy),
      .coexTxIndicator(txInd), .coexRxIndicator(rxInd), .macDiagIn(diagIn),
      .diagOut(diagOut), .externalRequest0(ext0), .externalRequest1(ext1),
      .ownActivityOut(ownAct), .ownPriorityOut(ownPri),
      .grantDecision(dec), .decisionClosing(closing));
   rca_ext_mac_model peer (.clock(clock), .reset_n(reset_n),
      .wantTx(wantTx), .wantRx(wantRx), .slow(slow),
      .externalRequest0(ext0), .externalRequest1(ext1));
   initial forever #12.5 clock = ~clock;
   // ----
   // Reference model and bus tasks
   // ----
   function automatic logic expAct();
      return macEvt && !ctrl[15] && !(ctrl[4] && decM == 2'h3);
   endfunction
   function automatic logic [31:0] expStat();
      return {16'h0, ctrl[15], 1'b0, ctrl[13], radioBusy, ext1, ext0,
         decM == 2'h1, expAct(), 1'b0, decM, 5'h0};
   endfunction
   function automatic logic expBusy(input logic [1:0] s);
      case (s)
         2'h0: return decM == 2'h1 && radioBusy;
         2'h1: return 1'b0;
         2'h2: return decM == 2'h3 || radioBusy;
         default: return decM == 2'h3;
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      bit aDone, dDone;
      aDone = 0;
      dDone = 0;
      awAddr <= a;
      wData <= {16'h0, d};
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      while (!(aDone && dDone)) begin
         @(posedge clock);
         aDone = aDone | awReady;
         dDone = dDone | wReady;
         awValid <= !aDone;
         wValid <= !dDone;
      end
      while (!bValid) @(posedge clock);
      lastResp = bResp;
      bReady <= 1'b0;
      // Idle edge so a following call never re-raises ready in this step
      @(posedge clock);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      @(posedge clock);
      while (!arReady) @(posedge clock);
      arValid <= 1'b0;
      while (!rValid) @(posedge clock);
      d = rData;
      lastResp = rResp;
      rReady <= 1'b0;
      @(posedge clock);
   endtask
   task automatic setCtrl(input logic [15:0] d);
      wr(12'h000, d);
      ctrl = d & `RCA_CTRL_WMASK;
      tick(4);
   endtask
   task automatic waitDec(input logic [1:0] e);
      for (int i = 0; i < 12 && dec !== e; i++) @(posedge clock);
      decM = e;
      check(dec, e);
   endtask
   task automatic busySweep();
      for (int s = 0; s < 8; s++) begin
         radioBusy <= s[0];
         setCtrl({3'h0, s[2:1], 11'h0});
         check(macBusy, expBusy(s[2:1]));
         rd(12'h008, rv);
         check(rv, expStat());
      end
   endtask
   // ----
   // Test sequence
   // ----
   initial begin
      seed = $urandom(32'haf73);
      tick(10);
      reset_n <= 1'b1;
      tick(2);
      rd(12'h000, rv);
      check(rv, 32'h0);
      rd(12'h004, rv);
      check(lastResp, `RCA_RESP_SLVERR);
      setCtrl(16'hffff);
      rd(12'h000, rv);
      check(rv, {16'h0, `RCA_CTRL_WMASK});
      setCtrl(16'h0000);
      wr(12'h008, 16'hffff);
      check(lastResp, `RCA_RESP_OKAY);
      rd(12'h008, rv);
      check(rv, 32'h0);
      $display("test registers done");
      macEvt <= 1'b1;
      waitDec(`RCA_DEC_INT);
      rd(12'h008, rv);
      check(rv, expStat());
      busySweep();
      macEvt <= 1'b0;
      waitDec(`RCA_DEC_NONE);
      setCtrl(16'h8000);
      macEvt <= 1'b1;
      tick(6);
      check(dec, `RCA_DEC_NONE);
      rd(12'h008, rv);
      check(rv, expStat());
      macEvt <= 1'b0;
      $display("test internal done");
      slow <= 1'b1;
      wantRx <= 1'b1;
      setCtrl(16'h0000);
      waitDec(`RCA_DEC_EXT);
      macEvt <= 1'b1;
      tick(3);
      rd(12'h008, rv);
      check(rv, expStat());
      setCtrl(16'h0010);
      check(ownAct, expAct());
      busySweep();
      for (int s = 0; s < 4; s++) begin
         diagIn <= 8'($urandom);
         setCtrl({9'h0, s[1:0], 5'h0});
         check(diagOut, s == 1 ? {diagIn[7:3], 1'b0, decM} : s == 2 ?
            {diagIn[7:6], 1'b0, decM, diagIn[2:0]} : diagIn);
      end
      setCtrl(16'h0400);
      check({txInd, rxInd}, 2'b01);
      macEvt <= 1'b0;
      setCtrl(16'h2000);
      check({txInd, rxInd}, 2'b00);
      waitDec(`RCA_DEC_NONE);
      rd(12'h008, rv);
      check(rv, expStat());
      {slow, wantRx, wantTx} <= 3'b001;
      tick(6);
      check(dec, `RCA_DEC_NONE);
      setCtrl(16'h0000);
      waitDec(`RCA_DEC_EXT);
      setCtrl(16'h0400);
      check({txInd, rxInd}, 2'b10);
      wantTx <= 1'b0;
      waitDec(`RCA_DEC_NONE);
      $display("test external done");
      macEvt <= 1'b1;
      waitDec(`RCA_DEC_INT);
      setCtrl(16'h0001);
      check(dec, `RCA_DEC_INT);
      macEvt <= 1'b0;
      waitDec(`RCA_DEC_NONE);
      macEvt <= 1'b1;
      tick(8);
      check(dec, `RCA_DEC_NONE);
      setCtrl(16'h0000);
      waitDec(`RCA_DEC_INT);
      macEvt <= 1'b0;
      tick(4);
      $display("test hold done");
      conclude();
   end
   initial begin
      #(25 * 20000);
      n_fail++;
      conclude();
   end
endmodule

// ==== dv/rca_ext_mac_model.sv ====
// Behavioural external MAC chip driving its two request pins
`timescale 1ns/1ps
module rca_ext_mac_model (
   // Clock and reset
   input wire clock,
   input wire reset_n,
   // Commands from the bench
   input wire wantTx,
   input wire wantRx,
   input wire slow,
   // Request pins
   output logic externalRequest0,
   output logic externalRequest1
);
   int waitCnt;
   // A slow chip lags its own decision by a few cycles
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         waitCnt <= 0;
         externalRequest0 <= 1'b0;
         externalRequest1 <= 1'b0;
      end else if (slow && waitCnt < 4 &&
                   {wantTx, wantRx} !=
                   {externalRequest0, externalRequest1}) begin
         waitCnt <= waitCnt + 1;
      end else begin
         waitCnt <= 0;
         externalRequest0 <= wantTx;
         externalRequest1 <= wantRx;
      end
   end
endmodule

// ==== src/rca_arbiter_ctrl.v ====
// Coexistence arbiter control, status and decision logic with AXI4-Lite
//
// Summary of operation
// - Ignore-internal bit masks internal activity
// - Ignore-external bit masks ORed external requests
// - Selector picks radio-busy source for MAC
// - Indicator enable drives tx/rx, else zero
// - Diagnostic selector: 0 untouched, 3 reserved
// - Overlay closing and decision on bits 2..0/5..3
// - Mode 0: own activity follows internal activity
// - Mode 1: own activity low when external granted
// - Hold bit: finish transaction, then no decisions
// - Hold bit captured on the arbiter clock
// - Status shows effective internal ignore state
// - Status shows effective external ignore state
// - Status shows radio busy; arbiter uses it delayed
// - Status shows second external request pin
// - Decision: 0 none, 1 internal, 3 external
// - Hold mode: no new decision, fall to none
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rca_defs.vh"

module rca_arbiter_ctrl #(
   parameter ADDR_W = 12,
   parameter DIAG_W = 8
) (
   // Clock and reset
   input wire clock,
   input wire reset_n,
   // AXI4-Lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // Internal MAC side
   input wire macEventInProcess,
   input wire radioCtrlBusy,
   output wire macRadioBusy,
   output wire coexTxIndicator,
   output wire coexRxIndicator,
   input wire [DIAG_W-1:0] macDiagIn,
   output wire [DIAG_W-1:0] diagOut,
   // External MAC pins
   input wire externalRequest0,
   input wire externalRequest1,
   output wire ownActivityOut,
   output wire ownPriorityOut,
   // Decision observation
   output wire [1:0] grantDecision,
   output wire decisionClosing
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg [1:0] ext0Sync_q;
   reg [1:0] ext1Sync_q;
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ext0Sync_q <= 2'h0;
         ext1Sync_q <= 2'h0;
      end else begin
         ext0Sync_q <= {ext0Sync_q[0], externalRequest0};
         ext1Sync_q <= {ext1Sync_q[0], externalRequest1};
      end
   end
   wire ext0 = ext0Sync_q[1];
   wire ext1 = ext1Sync_q[1];

   // ----------------------------------------------------------------
   // Control register and bus slave
   // ----------------------------------------------------------------
   reg [15:0] ctrl_q;
   reg awHeld_q;
   reg wHeld_q;
   reg [ADDR_W-1:0] awAddr_q;
   reg [31:0] wData_q;
   reg [3:0] wStrb_q;
   reg bValid_q;
   reg [1:0] bResp_q;
   reg rValid_q;
   reg [1:0] rResp_q;
   reg [31:0] rData_q;
   wire [15:0] statusWord;

   assign s_axi_awready = !awHeld_q && !bValid_q;
   assign s_axi_wready = !wHeld_q && !bValid_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = !rValid_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rresp = rResp_q;
   assign s_axi_rdata = rData_q;

   wire awFire = s_axi_awvalid && s_axi_awready;
   wire wFire = s_axi_wvalid && s_axi_wready;
   wire awHave = awHeld_q || awFire;
   wire wHave = wHeld_q || wFire;
   wire [ADDR_W-1:0] wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
   wire [31:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
   wire [3:0] wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
   wire doWrite = awHave && wHave && !bValid_q;
   wire [9:0] wrIdx = wrAddr[ADDR_W-1:2];
   wire [9:0] rdIdx = s_axi_araddr[ADDR_W-1:2];
   wire wrCtrl = wrIdx == `RCA_CTRL_IDX;
   wire wrStat = wrIdx == `RCA_STAT_IDX;
   wire [15:0] laneMask = {{8{wrStrb[1]}}, {8{wrStrb[0]}}};
   wire [15:0] ctrlBits = laneMask & `RCA_CTRL_WMASK;

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= `RCA_CTRL_RESET;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= {ADDR_W{1'b0}};
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q <= `RCA_RESP_OKAY;
      end else begin
         if (awFire) begin
            awAddr_q <= s_axi_awaddr;
         end
         if (wFire) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bValid_q <= 1'b1;
            // Status writes are accepted and dropped
            bResp_q <= (wrCtrl || wrStat) ? `RCA_RESP_OKAY
                                          : `RCA_RESP_SLVERR;
            if (wrCtrl) begin
               ctrl_q <= (ctrl_q & ~ctrlBits) |
                         (wrData[15:0] & ctrlBits);
            end
         end else begin
            awHeld_q <= awHeld_q || awFire;
            wHeld_q <= wHeld_q || wFire;
            bValid_q <= bValid_q && !s_axi_bready;
         end
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rValid_q <= 1'b0;
         rResp_q <= `RCA_RESP_OKAY;
         rData_q <= 32'h00000000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_q <= 1'b1;
         rResp_q <= `RCA_RESP_OKAY;
         if (rdIdx == `RCA_CTRL_IDX) begin
            rData_q <= {16'h0000, ctrl_q};
         end else if (rdIdx == `RCA_STAT_IDX) begin
            rData_q <= {16'h0000, statusWord};
         end else begin
            rData_q <= 32'h00000000;
            rResp_q <= `RCA_RESP_SLVERR;
         end
      end else if (rValid_q && s_axi_rready) begin
         rValid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Request masking
   // ----------------------------------------------------------------
   wire ignoreInt = ctrl_q[`RCA_C_IGN_INT];
   wire ignoreExt = ctrl_q[`RCA_C_IGN_EXT];
   // Gating is combinational so masking takes effect at once
   wire intActive = macEventInProcess && !ignoreInt;
   wire extActive = (ext0 || ext1) && !ignoreExt;

   // Arbiter sees radio busy one cycle late
   reg busyDly_q;
   // Hold bit captured on the arbiter clock
   reg hold_q;
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         busyDly_q <= 1'b0;
         hold_q <= 1'b0;
      end else begin
         busyDly_q <= radioCtrlBusy;
         hold_q <= ctrl_q[`RCA_C_HOLD];
      end
   end

   // ----------------------------------------------------------------
   // Decision state machine
   // ----------------------------------------------------------------
   localparam ST_NONE = 4'b0001;
   localparam ST_INT = 4'b0010;
   localparam ST_EXT = 4'b0100;
   localparam ST_CLOSE = 4'b1000;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [1:0] dec_q;
   reg [1:0] dec_d;

   // Internal MAC wins when both ask; a granted side keeps the radio
   // until its request drops, then one closing cycle returns to none.
   always @* begin
      state_d = state_q;
      dec_d = dec_q;
      case (state_q)
         ST_NONE: begin
            dec_d = `RCA_DEC_NONE;
            if (!hold_q && intActive) begin
               state_d = ST_INT;
               dec_d = `RCA_DEC_INT;
            end else if (!hold_q && extActive) begin
               state_d = ST_EXT;
               dec_d = `RCA_DEC_EXT;
            end
         end
         ST_INT: state_d = intActive ? ST_INT : ST_CLOSE;
         ST_EXT: state_d = extActive ? ST_EXT : ST_CLOSE;
         ST_CLOSE: begin
            state_d = ST_NONE;
            dec_d = `RCA_DEC_NONE;
         end
         default: begin
            state_d = ST_NONE;
            dec_d = `RCA_DEC_NONE;
         end
      endcase
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_NONE;
         dec_q <= `RCA_DEC_NONE;
      end else begin
         state_q <= state_d;
         dec_q <= dec_d;
      end
   end

   wire closing = state_q == ST_CLOSE;
   wire decInt = dec_q == `RCA_DEC_INT;
   wire decExt = dec_q == `RCA_DEC_EXT;
   assign grantDecision = dec_q;
   assign decisionClosing = closing;

   // ----------------------------------------------------------------
   // Outputs toward the internal MAC and the pins
   // ----------------------------------------------------------------
   reg busySel;
   always @* begin
      case (ctrl_q[`RCA_C_BUSY_HI:`RCA_C_BUSY_LO])
         `RCA_BUSY_INT_AND: busySel = decInt && busyDly_q;
         `RCA_BUSY_ZERO: busySel = 1'b0;
         `RCA_BUSY_EXT_OR: busySel = decExt || busyDly_q;
         default: busySel = decExt;
      endcase
   end

   wire indEn = ctrl_q[`RCA_C_IND_EN];
   // Mode 1 suppresses own activity while the external side owns it
   wire ownAct = intActive &&
                 !(ctrl_q[`RCA_C_OWN_MODE] && decExt);
   wire ownPri = decInt;

   reg [DIAG_W-1:0] diag_d;
   always @* begin
      diag_d = macDiagIn;
      case (ctrl_q[`RCA_C_DIAG_HI:`RCA_C_DIAG_LO])
         `RCA_DIAG_LOW: diag_d[2:0] = {closing, dec_q};
         `RCA_DIAG_HIGH: diag_d[5:3] = {closing, dec_q};
         default: diag_d = macDiagIn;
      endcase
   end

   reg busy_q;
   reg tx_q;
   reg rx_q;
   reg ownAct_q;
   reg ownPri_q;
   reg [DIAG_W-1:0] diag_q;
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         busy_q <= 1'b0;
         tx_q <= 1'b0;
         rx_q <= 1'b0;
         ownAct_q <= 1'b0;
         ownPri_q <= 1'b0;
         diag_q <= {DIAG_W{1'b0}};
      end else begin
         busy_q <= busySel;
         tx_q <= indEn && ext0;
         rx_q <= indEn && ext1;
         ownAct_q <= ownAct;
         ownPri_q <= ownPri;
         diag_q <= diag_d;
      end
   end
   assign macRadioBusy = busy_q;
   assign coexTxIndicator = tx_q;
   assign coexRxIndicator = rx_q;
   assign ownActivityOut = ownAct_q;
   assign ownPriorityOut = ownPri_q;
   assign diagOut = diag_q;

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   assign statusWord = {ignoreInt, 1'b0, ignoreExt, radioCtrlBusy,
                        ext1, ext0, ownPri_q, ownAct_q,
                        closing, dec_q, 5'h00};

endmodule

// ==== src/rca_defs.vh ====
// Register map, field positions and encodings of the coexistence arbiter
`ifndef RCA_DEFS_VH
`define RCA_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RCA_CTRL_OFFSET 32'h50002f00
`define RCA_STAT_OFFSET 32'h50002f02
`define RCA_CTRL_IDX 10'h000
`define RCA_STAT_IDX 10'h002
`define RCA_CTRL_RESET 16'h0000
`define RCA_CTRL_WMASK 16'hbc71

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define RCA_C_IGN_INT 15
`define RCA_C_IGN_EXT 13
`define RCA_C_BUSY_HI 12
`define RCA_C_BUSY_LO 11
`define RCA_C_IND_EN 10
`define RCA_C_DIAG_HI 6
`define RCA_C_DIAG_LO 5
`define RCA_C_OWN_MODE 4
`define RCA_C_HOLD 0

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define RCA_DEC_NONE 2'h0
`define RCA_DEC_INT 2'h1
`define RCA_DEC_EXT 2'h3
`define RCA_BUSY_INT_AND 2'h0
`define RCA_BUSY_ZERO 2'h1
`define RCA_BUSY_EXT_OR 2'h2
`define RCA_BUSY_EXT 2'h3
`define RCA_DIAG_NONE 2'h0
`define RCA_DIAG_LOW 2'h1
`define RCA_DIAG_HIGH 2'h2
`define RCA_RESP_OKAY 2'h0
`define RCA_RESP_SLVERR 2'h2

`endif
